//--- hdl/uflb_pkg.sv
// constants and types shared by the serial channel and its fifo
package uflb_pkg;
    // baud sampling and framing
    localparam int TICKS_PER_BIT = 16;
    localparam int SUB_W         = 4;
    localparam logic [SUB_W-1:0] SUB_LAST = 4'hf;
    localparam logic [SUB_W-1:0] SUB_MID  = 4'h7;
    localparam logic [2:0]       BIT_LAST = 3'h7;
    localparam int BITS_PER_CHAR = 10;
    // receive time-out, in character times and in 16x ticks
    localparam int TOUT_CHARS    = 4;
    localparam int TOUT_TICKS    = TOUT_CHARS * BITS_PER_CHAR * TICKS_PER_BIT;
    localparam int TOUT_W        = 10;
    localparam logic [TOUT_W-1:0] TOUT_LAST = TOUT_W'(TOUT_TICKS - 1);
    // fifo depths
    localparam int RX_DEPTH      = 16;
    localparam int TX_DEPTH      = 4;
    // receive trigger field codes and levels
    localparam logic [1:0] TRIG_CODE_1  = 2'h0;
    localparam logic [1:0] TRIG_CODE_4  = 2'h1;
    localparam logic [1:0] TRIG_CODE_8  = 2'h2;
    localparam logic [1:0] TRIG_CODE_14 = 2'h3;
    localparam logic [4:0] TRIG_LVL_1   = 5'h01;
    localparam logic [4:0] TRIG_LVL_4   = 5'h04;
    localparam logic [4:0] TRIG_LVL_8   = 5'h08;
    localparam logic [4:0] TRIG_LVL_14  = 5'h0e;
    // interrupt identification codes, bit 0 high means nothing pending
    localparam logic [3:0] ISR_NONE  = 4'h1;
    localparam logic [3:0] ISR_RX    = 4'h4;
    localparam logic [3:0] ISR_TOUT  = 4'hc;
    localparam logic [3:0] ISR_TX    = 4'h2;
    localparam logic [3:0] ISR_MODEM = 4'h0;
    // reset values
    localparam logic [15:0] DIV_RST  = 16'h0001;
    localparam logic        TXI_RST  = 1'b1;
    // modem delta bit positions
    localparam int MD_CTS = 0;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } uflb_txst_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } uflb_rxst_e;
endpackage : uflb_pkg

//--- hdl/uflb_fifo.sv
// small synchronous fifo with valid/ready on both sides and a fill count
`timescale 1ns/100ps
module uflb_fifo
    import uflb_pkg::*;
#(
    parameter int W = 8,
    parameter int D = TX_DEPTH
) (
    // clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   clkEn,
    // fill side
    input  wire logic                   inValid,
    output logic                        inReady,
    input  wire logic [W-1:0]           inData,
    // drain side
    output logic                        outValid,
    input  wire logic                   outReady,
    output logic [W-1:0]                outData,
    // fill level
    output logic [$clog2(D+1)-1:0]      count
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wrPtr;
        logic [PW-1:0]       rdPtr;
        logic [CW-1:0]       cnt;
    } uflb_fifo_s;

    uflb_fifo_s s_q;
    uflb_fifo_s s_d;
    logic       doPush;
    logic       doPop;

    assign inReady  = (s_q.cnt != CW'(D));
    assign outValid = (s_q.cnt != '0);
    assign outData  = s_q.mem[s_q.rdPtr];
    assign count    = s_q.cnt;
    assign doPush   = clkEn && inValid && inReady;
    assign doPop    = clkEn && outReady && outValid;

    always_comb begin
        s_d = s_q;
        if (doPush) begin
            s_d.mem[s_q.wrPtr] = inData;
            s_d.wrPtr = (s_q.wrPtr == PW'(D - 1)) ? '0 : s_q.wrPtr + 1'b1;
        end
        if (doPop) begin
            s_d.rdPtr = (s_q.rdPtr == PW'(D - 1)) ? '0 : s_q.rdPtr + 1'b1;
        end
        if (doPush && !doPop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (doPop && !doPush) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : uflb_fifo

//--- hdl/uflb_core.sv
// serial channel: baud generator, tx/rx, autoflow, interrupts, loop-back
`timescale 1ns/100ps
module uflb_core
    import uflb_pkg::*;
#(
    parameter int RxDepth = RX_DEPTH,
    parameter int TxDepth = TX_DEPTH
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // host transmit data into the transmit holding location
    input  wire logic [7:0]  txData,
    input  wire logic        txValid,
    output logic             txReady,
    // host reads of the receive holding location
    output logic [7:0]       rxData,
    output logic             rxValid,
    input  wire logic        rxReady,
    // divisor latches
    input  wire logic        divLatchEnable,
    input  wire logic        divLowWrite,
    input  wire logic        divHighWrite,
    input  wire logic [7:0]  divWriteData,
    output logic [15:0]      divisor,
    // fifo control bits
    input  wire logic        fifoEnable,
    input  wire logic        dmaModeSelect,
    input  wire logic [1:0]  rxTriggerCode,
    // interrupt enable bits
    input  wire logic        rxIntEnable,
    input  wire logic        txIntEnable,
    input  wire logic        modemIntEnable,
    // modem control bits
    input  wire logic        ctrlDtr,
    input  wire logic        ctrlRts,
    input  wire logic        userOutputOne,
    input  wire logic        userOutputTwo,
    input  wire logic        loopBack,
    input  wire logic        autoflowEnable,
    // status
    input  wire logic        intStatusRead,
    input  wire logic        modemStatusRead,
    output logic [3:0]       intStatus,
    output logic [7:0]       modemStatus,
    output logic             rxDataReady,
    output logic             txHoldEmpty,
    output logic [4:0]       rxFill,
    // serial pins
    output logic             txPin,
    input  wire logic        rxPin,
    output logic             rtsN,
    output logic             dtrN,
    output logic             out1N,
    output logic             out2N,
    input  wire logic        ctsN,
    input  wire logic        dsrN,
    input  wire logic        riN,
    input  wire logic        cdN,
    // interrupt output, three-state by enable
    input  wire logic        interruptSelectInput,
    output logic             intOut,
    output logic             intOutOeN
);
    localparam int RCW = $clog2(RxDepth + 1);
    localparam int TCW = $clog2(TxDepth + 1);

    typedef struct packed {
        logic [15:0]       divisor;
        logic [15:0]       baudCnt;
        uflb_txst_e        txSt;
        logic [SUB_W-1:0]  txSub;
        logic [2:0]        txBit;
        logic [7:0]        txShift;
        logic              txLine;
        logic              ctsGate;
        uflb_rxst_e        rxSt;
        logic [SUB_W-1:0]  rxSub;
        logic [2:0]        rxBit;
        logic [7:0]        rxShift;
        logic              rxPush;
        logic [7:0]        rxByte;
        logic [TOUT_W-1:0] toutCnt;
        logic              toutFlag;
        logic              rtsHold;
        logic [3:0]        msrNow;
        logic [3:0]        msrDelta;
        logic              txIntFlag;
        logic              txCondPrev;
        logic [3:0]        isr;
    } uflb_core_s;

    uflb_core_s s_q;
    uflb_core_s s_d;

    logic           tick;
    logic           serialIn;
    logic [3:0]     modemIn;
    logic           ctsActive;
    logic           autoCts;
    logic           autoRts;
    logic           txPop;
    logic           txFifoValid;
    logic [7:0]     txFifoData;
    logic [TCW-1:0] txCount;
    logic           txFifoReady;
    logic           rxPop;
    logic           rxStopCentre;
    logic [RCW-1:0] rxCount;
    logic [4:0]     trigLevel;
    logic           rtsBlock;
    logic           rxAvail;
    logic           toutPending;
    logic           txCond;
    logic           modemPending;

    // transmit holding fifo, back-pressure reaches the host
    uflb_fifo #(.W(8), .D(TxDepth)) txFifo (
        .clk      (clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (txValid),
        .inReady  (txFifoReady),
        .inData   (txData),
        .outValid (txFifoValid),
        .outReady (txPop),
        .outData  (txFifoData),
        .count    (txCount)
    );

    // receive fifo, a character arriving while full is lost
    uflb_fifo #(.W(8), .D(RxDepth)) rxFifo (
        .clk      (clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (s_q.rxPush),
        .inReady  (),
        .inData   (s_q.rxByte),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (rxData),
        .count    (rxCount)
    );

    assign txReady = clkEn && txFifoReady;
    assign rxPop   = clkEn && rxReady && rxValid;

    // one generator for both directions
    assign tick = (s_q.baudCnt + 16'h0001 >= s_q.divisor);

    // loop-back path and modem inputs
    assign serialIn = loopBack ? s_q.txLine : rxPin;
    assign modemIn  = loopBack ? {userOutputTwo, userOutputOne, ctrlDtr, ctrlRts}
                               : {~cdN, ~riN, ~dsrN, ~ctsN};
    assign ctsActive = modemIn[MD_CTS];

    // autoflow mode selection
    assign autoCts = autoflowEnable;
    assign autoRts = autoflowEnable && ctrlRts;

    // trigger level decode
    always_comb begin
        case (rxTriggerCode)
            TRIG_CODE_1: trigLevel = TRIG_LVL_1;
            TRIG_CODE_4: trigLevel = TRIG_LVL_4;
            TRIG_CODE_8: trigLevel = TRIG_LVL_8;
            default:     trigLevel = TRIG_LVL_14;
        endcase
    end

    // rts hold-off: level 14 tracks space, lower levels hold until empty
    always_comb begin
        if (rxTriggerCode == TRIG_CODE_14) begin
            rtsBlock = (rxCount == RCW'(RxDepth))
                    || (rxCount == RCW'(RxDepth - 1) && s_q.rxSt == RX_DATA);
        end else begin
            rtsBlock = s_q.rtsHold;
        end
    end

    // transmitter pops a byte when it starts a frame
    always_comb begin
        txPop = 1'b0;
        if (clkEn && tick && txFifoValid) begin
            if (s_q.txSt == TX_IDLE) begin
                txPop = !autoCts || ctsActive;
            end else if (s_q.txSt == TX_STOP && s_q.txSub == SUB_LAST) begin
                txPop = !autoCts || s_q.ctsGate;
            end
        end
    end

    assign rxStopCentre = tick && s_q.rxSt == RX_STOP && s_q.rxSub == SUB_LAST;

    // interrupt sources
    always_comb begin
        if (!fifoEnable) begin
            rxAvail = (rxCount != '0);
        end else if (dmaModeSelect) begin
            rxAvail = (5'(rxCount) > trigLevel);
        end else begin
            rxAvail = (5'(rxCount) >= trigLevel);
        end
    end
    assign toutPending  = s_q.toutFlag && (rxCount != '0);
    // fifo-enabled mode 0 reports the transmit fifo leaving full, otherwise an empty fifo
    assign txCond = (fifoEnable && !dmaModeSelect) ? txFifoReady
                                                   : (txCount == '0);
    // cts deltas are hidden from the interrupt while autoflow gates tx
    assign modemPending = autoflowEnable ? |s_q.msrDelta[3:1]
                                         : |s_q.msrDelta;

    always_comb begin
        s_d = s_q;
        s_d.rxPush = 1'b0;

        // divisor latches and baud counter
        if (divLatchEnable && divLowWrite) begin
            s_d.divisor[7:0] = divWriteData;
        end
        if (divLatchEnable && divHighWrite) begin
            s_d.divisor[15:8] = divWriteData;
        end
        s_d.baudCnt = tick ? 16'h0000 : s_q.baudCnt + 16'h0001;

        // transmitter
        if (tick) begin
            case (s_q.txSt)
                TX_IDLE: begin
                    s_d.txLine = 1'b1;
                    if (txPop) begin
                        s_d.txShift = txFifoData;
                        s_d.txSt    = TX_START;
                        s_d.txSub   = '0;
                        s_d.txLine  = 1'b0;
                    end
                end
                TX_START: begin
                    s_d.txSub = s_q.txSub + 1'b1;
                    if (s_q.txSub == SUB_LAST) begin
                        s_d.txSt   = TX_DATA;
                        s_d.txBit  = '0;
                        s_d.txLine = s_q.txShift[0];
                    end
                end
                TX_DATA: begin
                    s_d.txSub = s_q.txSub + 1'b1;
                    if (s_q.txSub == SUB_LAST) begin
                        s_d.txShift = {1'b0, s_q.txShift[7:1]};
                        s_d.txBit   = s_q.txBit + 1'b1;
                        s_d.txLine  = s_q.txShift[1];
                        if (s_q.txBit == BIT_LAST) begin
                            s_d.txSt   = TX_STOP;
                            s_d.txLine = 1'b1;
                        end
                    end
                end
                default: begin
                    s_d.txSub = s_q.txSub + 1'b1;
                    if (s_q.txSub == SUB_MID) begin
                        s_d.ctsGate = ctsActive;
                    end
                    if (s_q.txSub == SUB_LAST) begin
                        if (txPop) begin
                            s_d.txShift = txFifoData;
                            s_d.txSt    = TX_START;
                            s_d.txLine  = 1'b0;
                        end else begin
                            s_d.txSt = TX_IDLE;
                        end
                    end
                end
            endcase
        end

        // receiver, bits sampled at their centres
        if (tick) begin
            case (s_q.rxSt)
                RX_IDLE: begin
                    if (!serialIn) begin
                        s_d.rxSt  = RX_START;
                        s_d.rxSub = '0;
                    end
                end
                RX_START: begin
                    s_d.rxSub = s_q.rxSub + 1'b1;
                    if (s_q.rxSub == SUB_MID) begin
                        s_d.rxSub = '0;
                        s_d.rxBit = '0;
                        s_d.rxSt  = serialIn ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    s_d.rxSub = s_q.rxSub + 1'b1;
                    if (s_q.rxSub == SUB_LAST) begin
                        s_d.rxShift = {serialIn, s_q.rxShift[7:1]};
                        s_d.rxBit   = s_q.rxBit + 1'b1;
                        if (s_q.rxBit == BIT_LAST) begin
                            s_d.rxSt = RX_STOP;
                        end
                    end
                end
                default: begin
                    s_d.rxSub = s_q.rxSub + 1'b1;
                    if (s_q.rxSub == SUB_LAST) begin
                        s_d.rxPush = 1'b1;
                        s_d.rxByte = s_q.rxShift;
                        s_d.rxSt   = RX_IDLE;
                    end
                end
            endcase
        end

        // receive time-out
        if (rxStopCentre || rxPop || rxCount == '0) begin
            s_d.toutCnt  = '0;
            s_d.toutFlag = 1'b0;
        end else if (tick && !s_q.toutFlag) begin
            s_d.toutCnt = s_q.toutCnt + 1'b1;
            if (s_q.toutCnt == TOUT_LAST) begin
                s_d.toutFlag = 1'b1;
            end
        end

        // rts hold for the lower trigger levels, set wins over clear
        if (5'(rxCount) >= trigLevel) begin
            s_d.rtsHold = 1'b1;
        end else if (rxCount == '0) begin
            s_d.rtsHold = 1'b0;
        end

        // modem status and sticky deltas, a change beats the read clear
        s_d.msrNow   = modemIn;
        s_d.msrDelta = (modemStatusRead ? 4'h0 : s_q.msrDelta)
                     | (modemIn ^ s_q.msrNow);

        // transmit-empty flag: set on a new rise of txCond
        s_d.txCondPrev = txCond;
        if (txCond && !s_q.txCondPrev) begin
            s_d.txIntFlag = 1'b1;
        end else if ((txValid && txReady)
                  || (intStatusRead && s_q.isr == ISR_TX)) begin
            s_d.txIntFlag = 1'b0;
        end

        // single highest pending source
        if (rxIntEnable && rxAvail) begin
            s_d.isr = ISR_RX;
        end else if (rxIntEnable && toutPending) begin
            s_d.isr = ISR_TOUT;
        end else if (txIntEnable && s_q.txIntFlag) begin
            s_d.isr = ISR_TX;
        end else if (modemIntEnable && modemPending) begin
            s_d.isr = ISR_MODEM;
        end else begin
            s_d.isr = ISR_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q            <= '0;
            s_q.divisor    <= DIV_RST;
            s_q.txLine     <= 1'b1;
            s_q.txSt       <= TX_IDLE;
            s_q.rxSt       <= RX_IDLE;
            s_q.txIntFlag  <= TXI_RST;
            s_q.txCondPrev <= 1'b1;
            s_q.isr        <= ISR_NONE;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // outputs
    assign divisor     = s_q.divisor;
    assign intStatus   = s_q.isr;
    assign modemStatus = {s_q.msrNow, s_q.msrDelta};
    assign rxDataReady = (rxCount != '0);
    assign txHoldEmpty = txFifoReady;
    assign rxFill      = 5'(rxCount);

    // pins idle high while looped back
    assign txPin = loopBack ? 1'b1 : s_q.txLine;
    assign rtsN  = loopBack ? 1'b1 : !(ctrlRts && !(autoRts && rtsBlock));
    assign dtrN  = loopBack ? 1'b1 : !ctrlDtr;
    assign out1N = loopBack ? 1'b1 : !userOutputOne;
    assign out2N = loopBack ? 1'b1 : !userOutputTwo;

    // interrupt driver enabled by the select input or output-2
    assign intOut    = !s_q.isr[0];
    assign intOutOeN = !(interruptSelectInput || userOutputTwo);
endmodule : uflb_core

//--- dv/uflb_asserts.sv
// port checks for the serial channel core
`timescale 1ns/100ps
module uflb_asserts import uflb_pkg::*; (
    // clock, reset, divisor
    input wire logic clk, rst, clkEn, divLatchEnable, divLowWrite,
    input wire logic [7:0] divWriteData,
    input wire logic [15:0] divisor,
    // flow control and interrupt
    input wire logic [1:0] rxTriggerCode,
    input wire logic ctrlRts, userOutputTwo, loopBack, autoflowEnable,
    input wire logic [3:0] intStatus,
    input wire logic [4:0] rxFill,
    input wire logic txPin, rtsN, ctsN, interruptSelectInput, intOutOeN
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic autoRts;
    logic [4:0] lvl;
    logic [5:0] ctsOff;
    assign autoRts = autoflowEnable && ctrlRts && !loopBack;
    assign lvl = rxTriggerCode == 2'h0 ? TRIG_LVL_1 : rxTriggerCode == 2'h1 ? TRIG_LVL_4 : TRIG_LVL_8;
    // cycles that clear-to-send has been held off under autoflow
    always_ff @(posedge clk)
        ctsOff <= (rst || !ctsN || !autoflowEnable) ? 6'h0 : ctsOff + 6'(ctsOff != 6'h3f);
    int_drive_a: assert property (intOutOeN == !(interruptSelectInput || userOutputTwo))
        else $error("int enable wrong");
    loop_pins_a: assert property ($past(loopBack) && loopBack |-> txPin && rtsN)
        else $error("pins driven in loop-back");
    div_write_a: assert property (clkEn && divLatchEnable && divLowWrite |=>
        divisor[7:0] == $past(divWriteData)) else $error("divisor not written");
    div_locked_a: assert property (!divLatchEnable |=> $stable(divisor))
        else $error("divisor changed while locked");
    tout_fill_a: assert property (intStatus == ISR_TOUT |-> $past(rxFill) != 5'h0)
        else $error("time-out with empty fifo");
    rts_drop_a: assert property ((autoRts && rxTriggerCode != 2'h3 && rxFill >= lvl) [*2]
        |-> rtsN) else $error("rts not dropped");
    rts_back_a: assert property ((autoRts && rxFill == 5'h0) [*2] |-> !rtsN)
        else $error("rts not restored");
    cts_hold_a: assert property (!loopBack && ctsOff > 6'h28 |-> !$fell(txPin))
        else $error("sent while cts off");
    cover property (autoRts && rtsN);
    cover property (intStatus == ISR_TOUT);
    cover property (loopBack && rxFill != 5'h0);
endmodule : uflb_asserts

bind uflb_core uflb_asserts chk (.*);

//--- dv/uflb_remote.sv
// remote serial sender: frames bytes onto the receive line
`timescale 1ns/100ps
module uflb_remote #(
    parameter int BitClks = 16
) (
    input wire logic clk,
    output logic     line
);
    initial line = 1'b1;
    // 8N1, lsb first, line idles at mark between frames
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            line = i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i-1];
            repeat (BitClks) @(negedge clk);
        end
    endtask : send
endmodule : uflb_remote

//--- dv/tb_uart_flow_irq_baud_loopback.sv
// testbench for the serial channel core
`timescale 1ns/100ps
module tb_uart_flow_irq_baud_loopback import uflb_pkg::*; ;
    logic clk, rst, clkEn, txValid, rxReady, divLatchEnable, divLowWrite, divHighWrite;
    logic fifoEnable, dmaModeSelect, rxIntEnable, txIntEnable, modemIntEnable, ctrlDtr;
    logic ctrlRts, userOutputOne, userOutputTwo, loopBack, autoflowEnable, intStatusRead;
    logic modemStatusRead, ctsN, dsrN, riN, cdN, interruptSelectInput, txReady, rxValid;
    logic rxDataReady, txHoldEmpty, txPin, rxPin, rtsN, dtrN, out1N, out2N, intOut, intOutOeN;
    logic [7:0] txData, divWriteData, rxData, modemStatus;
    logic [1:0] rxTriggerCode;
    logic [15:0] divisor;
    logic [3:0] intStatus;
    logic [4:0] rxFill;
    int fail_count = 0, total_checks = 0, n;
    int lvl [4] = '{1, 4, 8, 14};
    always #5 clk = ~clk;
    uflb_core dut (.*);
    uflb_remote remote (.clk(clk), .line(rxPin));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic wait_lvl(input string what, ref logic sig, input logic val);
        for (n = 0; n < 500 && sig !== val; n++) @(negedge clk);
        chk(what, 16'(val), 16'(sig));
        if (sig !== val) stop_test();
    endtask : wait_lvl
    task automatic get_rx(input logic [7:0] b);
        chk("rxDataReady", 16'h1, 16'(rxDataReady));
        chk("rxData", 16'(b), 16'(rxData));
        rxReady = 1'b1;
        @(negedge clk);
        rxReady = 1'b0;
        @(negedge clk);
    endtask : get_rx
    task automatic div_wr(input logic en, input logic hi, input logic [7:0] d);
        {divLatchEnable, divHighWrite, divLowWrite, divWriteData} = {en, hi, !hi, d};
        @(negedge clk);
        {divHighWrite, divLowWrite} = 2'b00;
        @(negedge clk);
    endtask : div_wr
    initial begin
        {clk, txValid, rxReady, divLatchEnable, divLowWrite, divHighWrite, dmaModeSelect} = '0;
        {ctrlDtr, userOutputOne, userOutputTwo, loopBack, autoflowEnable, intStatusRead} = '0;
        {modemStatusRead, ctsN, interruptSelectInput, txData, divWriteData, rxTriggerCode} = '0;
        {rst, clkEn, fifoEnable, rxIntEnable, txIntEnable, modemIntEnable, ctrlRts} = '1;
        {dsrN, riN, cdN} = '1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("intStatus", 16'(ISR_TX), 16'(intStatus));
        chk("intOut", 16'h1, 16'(intOut));
        // the cts delta seen as reset lifts is cleared along with tx-empty
        {intStatusRead, modemStatusRead} = 2'b11;
        @(negedge clk);
        {intStatusRead, modemStatusRead} = 2'b00;
        repeat (2) @(negedge clk);
        chk("intStatus", 16'(ISR_NONE), 16'(intStatus));
        chk("intOut", 16'h0, 16'(intOut));
        div_wr(1'b0, 1'b0, 8'h55);
        chk("divisor", DIV_RST, divisor);
        div_wr(1'b1, 1'b0, 8'h03);
        div_wr(1'b1, 1'b1, 8'h02);
        chk("divisor", 16'h0203, divisor);
        div_wr(1'b1, 1'b1, 8'h00);
        div_wr(1'b1, 1'b0, 8'h01);
        dmaModeSelect = 1'b1;
        remote.send(8'h3c);
        repeat (4) @(negedge clk);
        chk("intStatus", 16'(ISR_NONE), 16'(intStatus));
        dmaModeSelect = 1'b0;
        repeat (3) @(negedge clk);
        chk("intStatus", 16'(ISR_RX), 16'(intStatus));
        get_rx(8'h3c);
        $display("test reset, divisor and dma done");
        autoflowEnable = 1'b1;
        for (int c = 0; c < 4; c++) begin
            rxTriggerCode = 2'(c);
            for (int i = 0; i < lvl[c]; i++) remote.send(8'(i + 16 * c));
            repeat (4) @(negedge clk);
            chk("rtsN", 16'(c != 3), 16'(rtsN));
            chk("intStatus", 16'(ISR_RX), 16'(intStatus));
            for (int i = 0; i < lvl[c]; i++) get_rx(8'(i + 16 * c));
            chk("rtsN", 16'h0, 16'(rtsN));
        end
        remote.send(8'h5a);
        for (n = 0; n < 900 && intStatus !== ISR_TOUT; n++) @(negedge clk);
        chk("timeout", 16'h1, 16'(n > 600 && n < 700));
        if (n == 900) stop_test();
        get_rx(8'h5a);
        chk("intStatus", 16'(ISR_NONE), 16'(intStatus));
        $display("test flow and time-out done");
        {loopBack, userOutputOne, txData, txValid} = {2'b11, 8'ha5, 1'b1};
        @(negedge clk);
        txValid = 1'b0;
        wait_lvl("rxValid", rxValid, 1'b1);
        get_rx(8'ha5);
        chk("modemStatus", 16'h5, 16'(modemStatus[7:4]));
        {intStatusRead, modemStatusRead} = 2'b11;
        @(negedge clk);
        {intStatusRead, modemStatusRead, ctrlRts} = 3'b000;
        repeat (4) @(negedge clk);
        chk("deltaCts", 16'h1, 16'(modemStatus[0]));
        chk("intStatus", 16'(ISR_NONE), 16'(intStatus));
        {loopBack, ctrlRts, ctsN, txData, txValid} = {3'b011, 8'h81, 1'b1};
        @(negedge clk);
        txValid = 1'b0;
        repeat (60) @(negedge clk);
        chk("txPin", 16'h1, 16'(txPin));
        ctsN = 1'b0;
        wait_lvl("txPin", txPin, 1'b0);
        chk("intOutOeN", 16'h1, 16'(intOutOeN));
        interruptSelectInput = 1'b1;
        @(negedge clk);
        chk("intOutOeN", 16'h0, 16'(intOutOeN));
        $display("test loop-back and cts done");
        stop_test();
    end
endmodule : tb_uart_flow_irq_baud_loopback
